// file: logic/limit_consts.svh
/*
 * Register offsets, field positions, reset values and setting codes for the
 * direction and overtravel limit block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef LIMIT_CONSTS_SVH
`define LIMIT_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DIR_OFS          8'h00
`define FWD_ALLOC_OFS    8'h04
`define REV_ALLOC_OFS    8'h08
`define STOP_METHOD_OFS  8'h0c
`define ESTOP_TORQ_OFS   8'h10
`define CTRL_OFS         8'h14
`define STATUS_OFS       8'h18

// ----------------------------------------------------------------
// setting codes and reset values
// ----------------------------------------------------------------
`define DIR_CCW_FWD      4'h0
`define DIR_CW_FWD       4'h1
`define FWD_ALLOC_RST    4'h1
`define REV_ALLOC_RST    4'h2
`define ALLOC_OFF        4'h8
`define STOP_DB          4'h0
`define STOP_DB_COAST    4'h1
`define STOP_COAST       4'h2
`define DECEL_NONE       4'h0
`define DECEL_CLAMP      4'h1
`define DECEL_COAST      4'h2
`define STOP_METHOD_RST  8'h00
`define ESTOP_TORQ_RST   10'h320
`define ESTOP_TORQ_MAX   10'h320

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_RESTART_BIT 0
`define ST_FWD_OT_BIT    0
`define ST_REV_OT_BIT    1
`define ST_STOPPING_BIT  2
`define ST_BASEBLK_BIT   3
`define ST_CLAMP_BIT     4
`define ST_DIR_CW_BIT    5

`endif

// file: logic/limit_pkg.sv
/*
 * Types shared by the direction and overtravel limit block.
 * Assumes nothing of its surroundings.
 */
package limit_pkg;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_DB_STOP,
        ST_COAST_STOP,
        ST_DECEL_STOP,
        ST_CLAMP_HOLD,
        ST_BASEBLOCK
    } stop_state_t;

    typedef struct packed {
        logic [7:0] stop_method;
        logic [3:0] rev_alloc;
        logic [3:0] fwd_alloc;
        logic [3:0] dir;
    } setup_t;

endpackage

// file: logic/ot_if.sv
/*
 * Carrier between the top and one overtravel channel.
 * Assumes the top drives pin and allocation, the channel answers the flag.
 */
`timescale 1ns/1ps
interface ot_if;
    logic       limit_pin;
    logic [3:0] alloc;
    logic       ot;

    modport chan (input limit_pin, input alloc, output ot);
    modport ctrl (output limit_pin, output alloc, input ot);
endinterface

// file: logic/ot_channel.sv
/*
 * One overtravel channel: a limit input gated by its allocation setting.
 * Assumes a synchronous limit input, high meaning switch closed (run allowed).
 */
`timescale 1ns/1ps
`include "limit_consts.svh"
module ot_channel (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // channel
    ot_if.chan        bus
);
    logic ot_ff;
    wire  enabled = (bus.alloc != `ALLOC_OFF);

    // open switch or broken wire reads as overtravel
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) ot_ff <= 1'b0;
        else          ot_ff <= enabled & ~bus.limit_pin;
    end

    assign bus.ot = ot_ff;
endmodule

// file: logic/setup_latch.sv
/*
 * Holds the active copy of restart-only settings.
 * Assumes load_i is a one-cycle restart pulse.
 */
`timescale 1ns/1ps
module setup_latch #(
    parameter int               W   = 20,
    parameter logic [W-1:0]     RST = '0
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // load
    input  wire logic         load_i,
    input  wire logic [W-1:0] pending_i,
    output logic      [W-1:0] active_o
);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)    active_o <= RST;
        else if (load_i) active_o <= pending_i;
    end
endmodule

// file: logic/direction_and_overtravel_limit.sv
/*
 * Direction and overtravel limit logic of a servo drive: forward-direction
 * selection, limit-switch run prohibition and the overtravel stop sequence.
 * Assumes synchronous inputs, one 25 MHz clock and a plain register port.
 */
// Chosen here: the address map and the address-and-strobe port.
// How it works
// - direction setting 0 makes ccw the forward direction, 1 makes cw forward.
// - reversing direction leaves reference polarity and encoder outputs untouched.
// - forward limit acts on forward references, reverse limit on reverse ones.
// - forward limit on allows forward running, off prohibits it and flags overtravel.
// - reverse limit on allows reverse running, off prohibits it and flags overtravel.
// - references away from the prohibited direction still pass during overtravel.
// - forward allocation 1 reads the pin, 8 ignores it and always allows forward.
// - reverse allocation 2 reads the pin, 8 ignores it and always allows reverse.
// - running into an active limit forces motion in that direction to stop.
// - after an overtravel stop the drive goes to baseblock unless zero clamp is chosen.
// - brake release stays asserted while in overtravel.
// - stop method selects dynamic brake, brake then coast, coast, or decel modes.
// - decel stops use an emergency torque of 0 to 800 percent, effective at once.
`timescale 1ns/1ps
`include "limit_consts.svh"
module direction_and_overtravel_limit #(
    parameter int REF_W = 16
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // register port
    input  wire logic [7:0]              addr_i,
    input  wire logic [31:0]             wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [31:0]             rdata_o,
    // limit switches
    input  wire logic                    forward_limit_input_i,
    input  wire logic                    reverse_limit_input_i,
    // motion reference path
    input  wire logic                    servo_on_i,
    input  wire logic signed [REF_W-1:0] ref_i,
    input  wire logic                    motor_stopped_i,
    output logic signed      [REF_W-1:0] ref_o,
    output logic                         motor_ccw_o,
    // encoder pulse pass-through
    input  wire logic                    encoder_phase_a_i,
    input  wire logic                    encoder_phase_b_i,
    output logic                         encoder_phase_a_out_o,
    output logic                         encoder_phase_b_out_o,
    // power stage and brake
    output logic                         dyn_brake_o,
    output logic                         baseblock_o,
    output logic                         decel_o,
    output logic                         zero_clamp_o,
    output logic      [9:0]              emergency_stop_torque_o,
    output logic                         brake_release_output_o,
    // status
    output logic                         fwd_ot_o,
    output logic                         rev_ot_o
);

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    limit_pkg::setup_t pend_ff;
    limit_pkg::setup_t act;
    logic [9:0]        torque_ff;
    logic [31:0]       rdata_ff;

    // one address compare serves both the write decode and the read mux
    function automatic logic at_ofs(input logic [7:0] a, input logic [7:0] ofs);
        return (a == ofs);
    endfunction

    wire wr_dir   = wr_i & at_ofs(addr_i, `DIR_OFS);
    wire wr_fwd   = wr_i & at_ofs(addr_i, `FWD_ALLOC_OFS);
    wire wr_rev   = wr_i & at_ofs(addr_i, `REV_ALLOC_OFS);
    wire wr_stop  = wr_i & at_ofs(addr_i, `STOP_METHOD_OFS);
    wire wr_torq  = wr_i & at_ofs(addr_i, `ESTOP_TORQ_OFS);
    wire restart  = wr_i & at_ofs(addr_i, `CTRL_OFS) & wdata_i[`CTRL_RESTART_BIT];

    // out-of-range torque writes saturate rather than wrap
    wire [9:0] torq_clip = (wdata_i[31:10] != 22'h000000 || wdata_i[9:0] > `ESTOP_TORQ_MAX)
                           ? `ESTOP_TORQ_MAX : wdata_i[9:0];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_ff.dir         <= `DIR_CCW_FWD;
            pend_ff.fwd_alloc   <= `FWD_ALLOC_RST;
            pend_ff.rev_alloc   <= `REV_ALLOC_RST;
            pend_ff.stop_method <= `STOP_METHOD_RST;
        end else begin
            if (wr_dir)  pend_ff.dir         <= wdata_i[3:0];
            if (wr_fwd)  pend_ff.fwd_alloc   <= wdata_i[3:0];
            if (wr_rev)  pend_ff.rev_alloc   <= wdata_i[3:0];
            if (wr_stop) pend_ff.stop_method <= wdata_i[7:0];
        end
    end

    // torque limit is live: no restart needed
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)     torque_ff <= `ESTOP_TORQ_RST;
        else if (wr_torq) torque_ff <= torq_clip;
    end

    // direction, allocation and stop method writes only touch the pending copy; restart moves it into service
    setup_latch #(
        .W   ($bits(limit_pkg::setup_t)),
        .RST ({`STOP_METHOD_RST, `REV_ALLOC_RST, `FWD_ALLOC_RST, `DIR_CCW_FWD})
    ) u_setup (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .load_i    (restart),
        .pending_i (pend_ff),
        .active_o  (act)
    );

    // ----------------------------------------------------------------
    // limit channels
    // ----------------------------------------------------------------
    ot_if ot_bus[2] ();

    wire [1:0] pins   = {reverse_limit_input_i, forward_limit_input_i};
    wire [7:0] allocs = {act.rev_alloc, act.fwd_alloc};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            assign ot_bus[g].limit_pin = pins[g];
            assign ot_bus[g].alloc     = allocs[g*4 +: 4];
            ot_channel u_ch (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .bus     (ot_bus[g])
            );
        end
    endgenerate

    wire fwd_ot = ot_bus[0].ot;
    wire rev_ot = ot_bus[1].ot;

    // ----------------------------------------------------------------
    // reference gating
    // ----------------------------------------------------------------
    // polarity of the reference defines forward, whatever the shaft does
    wire ref_fwd  = (ref_i > 0);
    wire ref_rev  = (ref_i < 0);
    wire blocked  = (ref_fwd & fwd_ot) | (ref_rev & rev_ot);
    wire ok_move  = (ref_fwd & ~fwd_ot) | (ref_rev & ~rev_ot);
    wire dir_cw   = (act.dir == `DIR_CW_FWD);

    wire signed [REF_W-1:0] nxt_ref =
        (servo_on_i && !blocked) ? ref_i : '0;
    // forward reference turns ccw unless reverse rotation mode is set
    wire nxt_ccw = (nxt_ref > 0) ^ dir_cw;

    // ----------------------------------------------------------------
    // overtravel stop sequence
    // ----------------------------------------------------------------
    limit_pkg::stop_state_t state_ff;
    limit_pkg::stop_state_t nxt_state;

    wire [3:0] method0 = act.stop_method[3:0];
    wire [3:0] method1 = act.stop_method[7:4];
    wire use_decel = (method1 == `DECEL_CLAMP) | (method1 == `DECEL_COAST);
    wire unblock   = ok_move | (~fwd_ot & ~rev_ot);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            limit_pkg::ST_RUN: begin
                if (servo_on_i && blocked) begin
                    if (use_decel)                 nxt_state = limit_pkg::ST_DECEL_STOP;
                    else if (method0 == `STOP_COAST) nxt_state = limit_pkg::ST_COAST_STOP;
                    else                           nxt_state = limit_pkg::ST_DB_STOP;
                end
            end
            limit_pkg::ST_DB_STOP,
            limit_pkg::ST_COAST_STOP: begin
                if (unblock)              nxt_state = limit_pkg::ST_RUN;
                else if (motor_stopped_i) nxt_state = limit_pkg::ST_BASEBLOCK;
            end
            limit_pkg::ST_DECEL_STOP: begin
                if (unblock)                       nxt_state = limit_pkg::ST_RUN;
                else if (motor_stopped_i) begin
                    if (method1 == `DECEL_CLAMP) nxt_state = limit_pkg::ST_CLAMP_HOLD;
                    else                         nxt_state = limit_pkg::ST_BASEBLOCK;
                end
            end
            limit_pkg::ST_CLAMP_HOLD,
            limit_pkg::ST_BASEBLOCK: begin
                if (unblock) nxt_state = limit_pkg::ST_RUN;
            end
            default: nxt_state = limit_pkg::ST_RUN;
        endcase
        if (!servo_on_i) nxt_state = limit_pkg::ST_RUN;
    end

    // dynamic brake held after stop only for the plain brake method
    wire nxt_db = (nxt_state == limit_pkg::ST_DB_STOP) |
                  ((nxt_state == limit_pkg::ST_BASEBLOCK) & (method0 == `STOP_DB) & ~use_decel);
    wire nxt_bb = ~servo_on_i | (nxt_state == limit_pkg::ST_DB_STOP) |
                  (nxt_state == limit_pkg::ST_COAST_STOP) |
                  (nxt_state == limit_pkg::ST_BASEBLOCK);
    wire nxt_decel = (nxt_state == limit_pkg::ST_DECEL_STOP);
    wire nxt_clamp = (nxt_state == limit_pkg::ST_CLAMP_HOLD);
    wire stopping  = (state_ff != limit_pkg::ST_RUN);

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff     <= limit_pkg::ST_RUN;
            ref_o        <= '0;
            motor_ccw_o  <= 1'b0;
            dyn_brake_o  <= 1'b0;
            baseblock_o  <= 1'b1;
            decel_o      <= 1'b0;
            zero_clamp_o <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            ref_o        <= nxt_ref;
            motor_ccw_o  <= nxt_ccw;
            dyn_brake_o  <= nxt_db;
            baseblock_o  <= nxt_bb;
            decel_o      <= nxt_decel;
            zero_clamp_o <= nxt_clamp;
        end
    end

    // brake stays released through overtravel: vertical axes need clamp mode
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) brake_release_output_o <= 1'b0;
        else          brake_release_output_o <= servo_on_i;
    end

    // encoder phases pass untouched by the direction setting
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            encoder_phase_a_out_o <= 1'b0;
            encoder_phase_b_out_o <= 1'b0;
        end else begin
            encoder_phase_a_out_o <= encoder_phase_a_i;
            encoder_phase_b_out_o <= encoder_phase_b_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fwd_ot_o                <= 1'b0;
            rev_ot_o                <= 1'b0;
            emergency_stop_torque_o <= `ESTOP_TORQ_RST;
        end else begin
            fwd_ot_o                <= fwd_ot;
            rev_ot_o                <= rev_ot;
            emergency_stop_torque_o <= torque_ff;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    wire [31:0] status_w = {26'h0000000, dir_cw, zero_clamp_o, baseblock_o,
                            stopping, rev_ot, fwd_ot};
    wire [31:0] rd_mux =
        at_ofs(addr_i, `DIR_OFS)         ? {28'h0000000, pend_ff.dir} :
        at_ofs(addr_i, `FWD_ALLOC_OFS)   ? {28'h0000000, pend_ff.fwd_alloc} :
        at_ofs(addr_i, `REV_ALLOC_OFS)   ? {28'h0000000, pend_ff.rev_alloc} :
        at_ofs(addr_i, `STOP_METHOD_OFS) ? {24'h000000, pend_ff.stop_method} :
        at_ofs(addr_i, `ESTOP_TORQ_OFS)  ? {22'h000000, torque_ff} :
        at_ofs(addr_i, `STATUS_OFS)      ? status_w : 32'h00000000;

    // data stand for one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)  rdata_ff <= 32'h00000000;
        else if (rd_i) rdata_ff <= rd_mux;
        else           rdata_ff <= 32'h00000000;
    end
    assign rdata_o = rdata_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    fwd_block_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (fwd_ot && ref_i > 0) |=> (ref_o == 0))
        else $error("forward reference passed during forward overtravel");

    rev_block_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (rev_ot && ref_i < 0) |=> (ref_o == 0))
        else $error("reverse reference passed during reverse overtravel");

    opposite_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (servo_on_i && fwd_ot && !rev_ot && ref_i < 0) |=> (ref_o == $past(ref_i)))
        else $error("reverse reference lost during forward overtravel");

    dir_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ref_o != 0) |-> (motor_ccw_o == ((ref_o > 0) != $past(dir_cw))))
        else $error("shaft direction does not match setting");

    enc_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ##1 (encoder_phase_a_out_o == $past(encoder_phase_a_i)))
        else $error("encoder phase altered");

    fwd_alloc_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (act.fwd_alloc == `ALLOC_OFF) [*2] |-> !fwd_ot)
        else $error("forward limit active while disabled");

    rev_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (act.rev_alloc != `ALLOC_OFF && !reverse_limit_input_i && $stable(act)) |=> rev_ot)
        else $error("reverse limit pin ignored");

    stop_entry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == limit_pkg::ST_RUN && servo_on_i && blocked) |=> (stopping && ref_o == 0))
        else $error("no stop on overtravel");

    clamp_or_bb_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == limit_pkg::ST_DECEL_STOP && motor_stopped_i && servo_on_i && !unblock)
        |=> (zero_clamp_o != baseblock_o))
        else $error("wrong mode after overtravel stop");

    brake_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (servo_on_i && (fwd_ot || rev_ot)) |=> brake_release_output_o)
        else $error("brake engaged during overtravel");

    restart_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !restart |=> $stable(act))
        else $error("setting changed without restart");

    torque_now_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_torq |=> ##1 (emergency_stop_torque_o <= `ESTOP_TORQ_MAX &&
                         emergency_stop_torque_o == $past(torq_clip, 2)))
        else $error("emergency torque not applied");

    fwd_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (act.fwd_alloc != `ALLOC_OFF && !forward_limit_input_i) |=> fwd_ot)
        else $error("forward limit pin ignored");

    decel_pick_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == limit_pkg::ST_RUN && servo_on_i && blocked)
        |=> (decel_o == $past(use_decel)))
        else $error("stop method not followed");

    bb_after_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_ff == limit_pkg::ST_BASEBLOCK) |-> (baseblock_o && !zero_clamp_o))
        else $error("baseblock state with torque on");

endmodule

// file: tb/limit_partner.sv
/*
 * Far side model: two limit switches and a shaft that coasts to rest.
 * Assumes the bench opens and closes the switches by level.
 */
`timescale 1ns/1ps
module limit_partner #(
    parameter int LAT = 6
) (
    // clock and commands
    input  wire logic        clk_i,
    input  wire logic        fwd_open_i,
    input  wire logic        rev_open_i,
    input  wire logic [15:0] drive_i,
    // to the drive
    output logic             fwd_pin_o,
    output logic             rev_pin_o,
    output logic             stopped_o
);
    int cnt = 0;
    // normally closed contacts: an open switch or a cut wire reads low
    assign fwd_pin_o = !fwd_open_i;
    assign rev_pin_o = !rev_open_i;
    // shaft needs LAT cycles without drive to come to rest, so stops are not instant
    always @(posedge clk_i) begin
        cnt <= (drive_i != 16'h0000) ? 0 : ((cnt < LAT) ? cnt + 1 : cnt);
    end
    assign stopped_o = (cnt == LAT);
endmodule

// file: tb/direction_and_overtravel_limit_tb.sv
/*
 * Bench for the direction and overtravel limit block.
 * Assumes the plain register port contract and limit_partner on the switches.
 */
`timescale 1ns/1ps
`include "limit_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module direction_and_overtravel_limit_tb;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        son = 1'b0;
    logic [15:0] ref_i = 16'h0;
    logic        ea = 1'b0;
    logic        eb = 1'b0;
    logic        fo = 1'b0;
    logic        ro = 1'b0;
    wire  [31:0] rdata_o;
    wire  [15:0] ref_o;
    wire  [9:0]  torq;
    wire         ccw, eao, ebo, db, bb, dec, zc, brk, fot, rot, fpin, rpin, stopped;
    int          err_total = 0;
    int          compares = 0;
    logic [7:0]  mt [5] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20};
    logic        de [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [2:0]  aft [5] = '{3'b110, 3'b010, 3'b010, 3'b001, 3'b010};

    always #20 clk_i = ~clk_i;

    direction_and_overtravel_limit #(.REF_W(16)) u_direction_and_overtravel_limit (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .forward_limit_input_i(fpin), .reverse_limit_input_i(rpin),
        .servo_on_i(son), .ref_i(ref_i), .motor_stopped_i(stopped),
        .ref_o(ref_o), .motor_ccw_o(ccw),
        .encoder_phase_a_i(ea), .encoder_phase_b_i(eb),
        .encoder_phase_a_out_o(eao), .encoder_phase_b_out_o(ebo),
        .dyn_brake_o(db), .baseblock_o(bb), .decel_o(dec), .zero_clamp_o(zc),
        .emergency_stop_torque_o(torq), .brake_release_output_o(brk),
        .fwd_ot_o(fot), .rev_ot_o(rot));

    limit_partner #(.LAT(6)) u_limit_partner (
        .clk_i(clk_i), .fwd_open_i(fo), .rev_open_i(ro), .drive_i(ref_o),
        .fwd_pin_o(fpin), .rev_pin_o(rpin), .stopped_o(stopped));

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic complete_run;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask

    // reference and switches change together, then the flags get time to settle
    task automatic move(input logic [15:0] r, input logic f, input logic v);
        @(posedge clk_i);
        ref_i <= r;
        fo <= f;
        ro <= v;
        step(4);
    endtask

    task automatic wait_stop;
        int i;
        for (i = 0; i < 100 && stopped !== 1'b1; i++)
            step(1);
        if (stopped !== 1'b1) begin
            err_total++;
            complete_run();
        end
        step(3);
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        step(1);
        `CHK(bb, 1'b1)
        `CHK(torq, 10'h320)
        rd(`DIR_OFS, 32'h0);
        rd(`FWD_ALLOC_OFS, 32'h1);
        rd(`REV_ALLOC_OFS, 32'h2);
        rd(`STOP_METHOD_OFS, 32'h0);
        rd(`ESTOP_TORQ_OFS, 32'h320);
        rd(8'h3c, 32'h0);
        wr(`ESTOP_TORQ_OFS, 32'h64);
        step(1);
        `CHK(torq, 10'h064)
        wr(`ESTOP_TORQ_OFS, 32'h384);
        step(1);
        `CHK(torq, 10'h320)
        @(posedge clk_i);
        ea <= 1'b1;
        son <= 1'b1;
        step(2);
        `CHK({eao, ebo}, 2'b10)
        move(16'h0064, 1'b0, 1'b0);
        `CHK(ref_o, 16'h0064)
        `CHK(ccw, 1'b1)
        move(16'hff9c, 1'b0, 1'b0);
        `CHK(ccw, 1'b0)
        for (int k = 0; k < 5; k++) begin
            wr(`STOP_METHOD_OFS, {24'h0, mt[k]});
            wr(`CTRL_OFS, 32'h1);
            move(16'h0064, 1'b0, 1'b0);
            move(16'h0064, 1'b1, 1'b0);
            `CHK(ref_o, 16'h0000)
            `CHK(fot, 1'b1)
            `CHK(dec, de[k])
            wait_stop();
            `CHK({db, bb, zc}, aft[k])
            `CHK(brk, 1'b1)
            move(16'hff9c, 1'b1, 1'b0);
            `CHK(ref_o, 16'hff9c)
            move(16'h0000, 1'b0, 1'b0);
        end
        move(16'hff9c, 1'b0, 1'b1);
        `CHK({rot, fot, ref_o}, {2'b10, 16'h0000})
        move(16'h0064, 1'b0, 1'b1);
        `CHK(ref_o, 16'h0064)
        rd(`STATUS_OFS, 32'h2);
        wr(`FWD_ALLOC_OFS, 32'h8);
        wr(`REV_ALLOC_OFS, 32'h8);
        wr(`CTRL_OFS, 32'h1);
        move(16'h0064, 1'b1, 1'b1);
        `CHK({fot, ref_o}, {1'b0, 16'h0064})
        move(16'hff9c, 1'b1, 1'b1);
        `CHK({rot, ref_o}, {1'b0, 16'hff9c})
        wr(`FWD_ALLOC_OFS, 32'h1);
        wr(`REV_ALLOC_OFS, 32'h2);
        wr(`CTRL_OFS, 32'h1);
        move(16'h0064, 1'b0, 1'b0);
        wr(`DIR_OFS, 32'h1);
        step(2);
        `CHK(ccw, 1'b1)
        rd(`DIR_OFS, 32'h1);
        wr(`CTRL_OFS, 32'h1);
        @(posedge clk_i);
        eb <= 1'b1;
        step(2);
        `CHK({ccw, ref_o}, {1'b0, 16'h0064})
        `CHK({eao, ebo}, 2'b11)
        rd(`STATUS_OFS, 32'h20);
        move(16'h0064, 1'b1, 1'b0);
        `CHK({fot, ref_o}, {1'b1, 16'h0000})
        complete_run();
    end
endmodule
